/* hdl/area_width_decode.sv */
// area_width_decode: tells whether the accessed area is a 16-bit area
module area_width_decode (
	// width fields, high and low bit of each area
	input wire logic [chip_select_pkg::NUM_AREAS-1:0] width_hi_in,
	input wire logic [chip_select_pkg::NUM_AREAS-1:0] width_lo_in,
	// accessed area
	input wire logic [chip_select_pkg::AREA_W-1:0] area_in,
	// result
	output logic wide_out
);

	always_comb begin
		wide_out = ({width_hi_in[area_in], width_lo_in[area_in]}
			== chip_select_pkg::WIDTH_FIELD_16);
	end

endmodule

/* hdl/chip_select_pin_enable.sv */
// chip_select_pin_enable: chip-select pin function control and data port use
//
// Function
// - one enable bit per select, bit n
// - cleared bit leaves pin as port pin
// - set bit drives active-low select onto pin
// - upper data port is bus only for 01
// - enabled select goes to chosen pin; some prohibited
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
module chip_select_pin_enable (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// register port
	input wire logic [chip_select_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [chip_select_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [chip_select_pkg::DATA_W-1:0] reg_rdata_out,
	// bus controller side
	input wire logic [chip_select_pkg::NUM_CS-1:0] area_select_output_b_in,
	input wire logic [chip_select_pkg::AREA_W-1:0] access_area_in,
	input wire logic [7:0] data_hi_in,
	input wire logic data_hi_drive_in,
	// select-capable pins
	output logic [chip_select_pkg::NUM_PINS-1:0] select_pin_level_out,
	output logic [chip_select_pkg::NUM_PINS-1:0] select_pin_mode_out,
	// upper data port
	output logic upper_data_port_bus_mode_out,
	output logic [7:0] upper_data_port_out,
	output logic upper_data_port_oe_out
);

	typedef struct packed {
		logic [7:0] chip_select_output_enable;
		logic [7:0] select_pin_choice_register;
		logic cs2_choice;
		logic [7:0] width_hi;
		logic [7:0] width_lo;
		logic [7:0] rdata;
		logic [chip_select_pkg::NUM_PINS-1:0] pin_mode;
		logic [chip_select_pkg::NUM_PINS-1:0] pin_level;
		logic [chip_select_pkg::NUM_CS-1:0] prohibited;
		logic upper_bus_mode;
		logic [7:0] upper_data;
		logic upper_oe;
	} state_s;

	localparam state_s STATE_RESET = '{
		chip_select_output_enable: chip_select_pkg::CS_ENABLE_RESET,
		select_pin_choice_register: chip_select_pkg::PIN_CHOICE_RESET,
		cs2_choice: chip_select_pkg::CS2_CHOICE_RESET,
		width_hi: chip_select_pkg::WIDTH_HI_RESET,
		width_lo: chip_select_pkg::WIDTH_LO_RESET,
		rdata: 8'h00,
		pin_mode: '0,
		pin_level: '1,
		prohibited: '0,
		upper_bus_mode: 1'h0,
		upper_data: 8'h00,
		upper_oe: 1'h0
	};

	state_s st_r;
	state_s st_nxt;

	// per-select pin code and routing result
	logic [1:0] code [chip_select_pkg::NUM_CS];
	logic [chip_select_pkg::NUM_PINS-1:0] hit [chip_select_pkg::NUM_CS];
	logic [chip_select_pkg::NUM_CS-1:0] prohibited;
	logic upper_wide;

	// next values of the software-written registers
	logic [7:0] enable_nxt;
	logic [7:0] choice_nxt;
	logic cs2_choice_nxt;
	logic [7:0] width_hi_nxt;
	logic [7:0] width_lo_nxt;

	// decoded apart from the state struct so that the pin routing reads
	// no part of st_nxt and cannot form a loop back through it
	always_comb begin
		enable_nxt = st_r.chip_select_output_enable;
		choice_nxt = st_r.select_pin_choice_register;
		cs2_choice_nxt = st_r.cs2_choice;
		width_hi_nxt = st_r.width_hi;
		width_lo_nxt = st_r.width_lo;
		// the slave never stalls; unmapped offsets are ignored
		if (reg_write_in) begin
			case (reg_addr_in)
				chip_select_pkg::OFS_CS_ENABLE: begin
					enable_nxt = reg_wdata_in;
				end
				chip_select_pkg::OFS_PIN_CHOICE: begin
					choice_nxt = reg_wdata_in;
				end
				chip_select_pkg::OFS_CS2_CHOICE: begin
					cs2_choice_nxt =
						reg_wdata_in[chip_select_pkg::CS2_CHOICE_BIT];
				end
				chip_select_pkg::OFS_WIDTH_HI: begin
					width_hi_nxt = reg_wdata_in;
				end
				chip_select_pkg::OFS_WIDTH_LO: begin
					width_lo_nxt = reg_wdata_in;
				end
				default: begin
				end
			endcase
		end
	end

	// the pin code comes from the next register values so that a write
	// reaches the pins at the same edge it lands in the register
	always_comb begin
		for (int n = 0; n < chip_select_pkg::NUM_CS; n++) begin
			code[n] = 2'h0;
			if (n >= chip_select_pkg::PIN_CHOICE_FIRST_CS) begin
				code[n] = choice_nxt[
					2 * (n - chip_select_pkg::PIN_CHOICE_FIRST_CS) +: 2];
			end else if (n == chip_select_pkg::CS2_INDEX) begin
				code[n] = {1'h0, cs2_choice_nxt};
			end
		end
	end

	for (genvar g = 0; g < chip_select_pkg::NUM_CS; g++) begin : g_route
		cs_pin_route #(
			.MAP(chip_select_pkg::ROUTE_MAP[g])
		) u_route (
			.enable_in(enable_nxt[g]),
			.code_in(code[g]),
			.pin_hit_out(hit[g]),
			.prohibited_out(prohibited[g])
		);
	end

	area_width_decode u_width (
		.width_hi_in(width_hi_nxt),
		.width_lo_in(width_lo_nxt),
		.area_in(access_area_in),
		.wide_out(upper_wide)
	);

	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = 8'h00;

		// register writes land at the same edge as their pin effect
		st_nxt.chip_select_output_enable = enable_nxt;
		st_nxt.select_pin_choice_register = choice_nxt;
		st_nxt.cs2_choice = cs2_choice_nxt;
		st_nxt.width_hi = width_hi_nxt;
		st_nxt.width_lo = width_lo_nxt;

		// read data stand for exactly the cycle after the strobe
		if (reg_read_in) begin
			case (reg_addr_in)
				chip_select_pkg::OFS_CS_ENABLE: begin
					st_nxt.rdata = st_r.chip_select_output_enable;
				end
				chip_select_pkg::OFS_PIN_CHOICE: begin
					st_nxt.rdata = st_r.select_pin_choice_register;
				end
				chip_select_pkg::OFS_CS2_CHOICE: begin
					st_nxt.rdata = {7'h00, st_r.cs2_choice};
				end
				chip_select_pkg::OFS_WIDTH_HI: begin
					st_nxt.rdata = st_r.width_hi;
				end
				chip_select_pkg::OFS_WIDTH_LO: begin
					st_nxt.rdata = st_r.width_lo;
				end
				chip_select_pkg::OFS_PIN_MODE_LO: begin
					st_nxt.rdata = st_r.pin_mode[7:0];
				end
				chip_select_pkg::OFS_PIN_MODE_HI: begin
					st_nxt.rdata = {6'h00, st_r.pin_mode[9:8]};
				end
				chip_select_pkg::OFS_PROHIBITED: begin
					st_nxt.rdata = st_r.prohibited;
				end
				chip_select_pkg::OFS_PIN_LEVEL_LO: begin
					st_nxt.rdata = st_r.pin_level[7:0];
				end
				chip_select_pkg::OFS_PIN_LEVEL_HI: begin
					st_nxt.rdata = {6'h00, st_r.pin_level[9:8]};
				end
				default: begin
					st_nxt.rdata = 8'h00;
				end
			endcase
		end

		// pin function and level; selects sharing a pin are ANDed, so the
		// pin goes low whenever any of them is active
		st_nxt.pin_mode = '0;
		st_nxt.pin_level = '1;
		for (int n = 0; n < chip_select_pkg::NUM_CS; n++) begin
			st_nxt.pin_mode = st_nxt.pin_mode | hit[n];
			for (int p = 0; p < chip_select_pkg::NUM_PINS; p++) begin
				if (hit[n][p] && !area_select_output_b_in[n]) begin
					st_nxt.pin_level[p] = 1'h0;
				end
			end
		end
		st_nxt.prohibited = prohibited;

		// upper data port carries bus bits 15..8 only for 16-bit areas
		st_nxt.upper_bus_mode = upper_wide;
		st_nxt.upper_data = upper_wide ? data_hi_in : 8'h00;
		st_nxt.upper_oe = upper_wide && data_hi_drive_in;
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_r <= STATE_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state register
	always_comb begin
		reg_rdata_out = st_r.rdata;
		select_pin_level_out = st_r.pin_level;
		select_pin_mode_out = st_r.pin_mode;
		upper_data_port_bus_mode_out = st_r.upper_bus_mode;
		upper_data_port_out = st_r.upper_data;
		upper_data_port_oe_out = st_r.upper_oe;
	end

endmodule

/* hdl/chip_select_pkg.sv */
// package: constants for the chip-select pin enable block
package chip_select_pkg;

	// sizes
	localparam int NUM_CS = 8;
	localparam int NUM_PINS = 10;
	localparam int NUM_AREAS = 8;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int PIN_IDX_W = 4;
	localparam int AREA_W = 3;

	// pin indices of the pins that can carry a chip select
	localparam logic [3:0] PIN_CS0 = 4'h0;
	localparam logic [3:0] PIN_CS1 = 4'h1;
	localparam logic [3:0] PIN_CS3 = 4'h2;
	localparam logic [3:0] PIN_PB0 = 4'h3;
	localparam logic [3:0] PIN_PB1 = 4'h4;
	localparam logic [3:0] PIN_PB2 = 4'h5;
	localparam logic [3:0] PIN_PB3 = 4'h6;
	localparam logic [3:0] PIN_PF5 = 4'h7;
	localparam logic [3:0] PIN_PF6 = 4'h8;
	localparam logic [3:0] PIN_PF7 = 4'h9;
	localparam logic [3:0] PIN_NONE = 4'hF;

	// routing per chip select: nibble k is the pin for select code k
	localparam logic [15:0] ROUTE_MAP [NUM_CS] = '{
		16'h0000,
		16'h1111,
		16'hFF45,
		16'h2222,
		16'hF9F3,
		16'h7934,
		16'h8945,
		16'hF946
	};

	// register offsets
	localparam logic [3:0] OFS_CS_ENABLE = 4'h0;
	localparam logic [3:0] OFS_PIN_CHOICE = 4'h1;
	localparam logic [3:0] OFS_CS2_CHOICE = 4'h2;
	localparam logic [3:0] OFS_WIDTH_HI = 4'h3;
	localparam logic [3:0] OFS_WIDTH_LO = 4'h4;
	localparam logic [3:0] OFS_PIN_MODE_LO = 4'h5;
	localparam logic [3:0] OFS_PIN_MODE_HI = 4'h6;
	localparam logic [3:0] OFS_PROHIBITED = 4'h7;
	localparam logic [3:0] OFS_PIN_LEVEL_LO = 4'h8;
	localparam logic [3:0] OFS_PIN_LEVEL_HI = 4'h9;

	// field positions
	localparam int PIN_CHOICE_FIRST_CS = 4;
	localparam int CS2_CHOICE_BIT = 0;
	localparam int CS2_INDEX = 2;

	// reset values
	localparam logic [7:0] CS_ENABLE_RESET = 8'h01;
	localparam logic [7:0] PIN_CHOICE_RESET = 8'h00;
	localparam logic CS2_CHOICE_RESET = 1'h0;
	localparam logic [7:0] WIDTH_HI_RESET = 8'h00;
	localparam logic [7:0] WIDTH_LO_RESET = 8'hFF;

	// area width field code that makes the upper data port a data bus
	localparam logic [1:0] WIDTH_FIELD_16 = 2'h1;

endpackage

/* hdl/cs_pin_route.sv */
// cs_pin_route: decodes one chip select's enable and pin code to pin hits
module cs_pin_route #(
	parameter logic [15:0] MAP = 16'hFFFF
) (
	// control
	input wire logic enable_in,
	input wire logic [1:0] code_in,
	// result
	output logic [chip_select_pkg::NUM_PINS-1:0] pin_hit_out,
	output logic prohibited_out
);

	logic [3:0] pin_idx;

	always_comb begin
		pin_idx = MAP[{code_in, 2'h0} +: 4];
		pin_hit_out = '0;
		prohibited_out = 1'h0;
		if (enable_in) begin
			if (pin_idx == chip_select_pkg::PIN_NONE) begin
				// a forbidden code leaves every pin to its port function
				prohibited_out = 1'h1;
			end else begin
				pin_hit_out[pin_idx] = 1'h1;
			end
		end
	end

endmodule

/* tb/chip_select_pin_enable_chk.sv */
// checker: port properties of the chip-select pin enable block
module chip_select_pin_enable_chk (
	// clock, reset and register port
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [7:0] reg_rdata_out,
	// bus controller side and pins
	input wire logic [7:0] area_select_output_b_in,
	input wire logic [2:0] access_area_in,
	input wire logic [7:0] data_hi_in,
	input wire logic data_hi_drive_in,
	input wire logic [9:0] select_pin_level_out,
	input wire logic [9:0] select_pin_mode_out,
	input wire logic upper_data_port_bus_mode_out,
	input wire logic [7:0] upper_data_port_out,
	input wire logic upper_data_port_oe_out
);
	// shadow of the enable register, since only the ports are visible
	logic [7:0] en_r;
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			en_r <= 8'h01;
		end else if (reg_write_in && reg_addr_in == 4'h0) begin
			en_r <= reg_wdata_in;
		end
	end
	sequence s_en_wr;
		reg_write_in && reg_addr_in == 4'h0;
	endsequence
	sequence s_cs1_low;
		!area_select_output_b_in[1] ##1 en_r[1];
	endsequence
	a_cs0_enable: assert property (
		s_en_wr |=> select_pin_mode_out[0] == en_r[0]) else $error("cs0 mode");
	a_cs1_level: assert property (
		s_cs1_low |-> !select_pin_level_out[1]) else $error("cs1 level");
	a_port_idle: assert property (
		!select_pin_mode_out[2] |-> select_pin_level_out[2])
		else $error("idle level");
	a_reset_val: assert property (
		$rose(rst_b_in) |=> select_pin_mode_out == 10'h001)
		else $error("reset mode");
	a_rd_enable: assert property (
		reg_read_in && reg_addr_in == 4'h0 |=> reg_rdata_out == $past(en_r))
		else $error("read data");
	a_rd_idle: assert property (
		!reg_read_in |=> reg_rdata_out == 8'h00) else $error("rdata idle");
	a_bus_data: assert property (
		upper_data_port_bus_mode_out |-> upper_data_port_out == $past(data_hi_in)
		&& upper_data_port_oe_out == $past(data_hi_drive_in))
		else $error("upper data");
	a_port_off: assert property (
		!upper_data_port_bus_mode_out |-> upper_data_port_out == 8'h00
		&& !upper_data_port_oe_out) else $error("upper off");
	a_shared_pins: assert property (
		|select_pin_mode_out[9:3] |-> |en_r[7:2]) else $error("shared pin");
endmodule

bind chip_select_pin_enable chip_select_pin_enable_chk i_chk (.clk_in,
	.rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
	.reg_rdata_out, .area_select_output_b_in, .access_area_in, .data_hi_in,
	.data_hi_drive_in, .select_pin_level_out, .select_pin_mode_out,
	.upper_data_port_bus_mode_out, .upper_data_port_out,
	.upper_data_port_oe_out);

/* tb/testbench.sv */
// testbench: directed checks of the chip-select pin enable block
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'h0;
	logic rst_b_in = 1'h0;
	logic [3:0] reg_addr_in = 4'h0;
	logic [7:0] reg_wdata_in = 8'h00;
	logic reg_write_in = 1'h0;
	logic reg_read_in = 1'h0;
	logic [7:0] area_select_output_b_in = 8'hFF;
	logic [2:0] access_area_in = 3'h0;
	logic [7:0] data_hi_in = 8'hA5;
	logic data_hi_drive_in = 1'h1;
	logic [7:0] reg_rdata_out;
	logic [7:0] upper_data_port_out;
	logic [9:0] select_pin_level_out;
	logic [9:0] select_pin_mode_out;
	logic upper_data_port_bus_mode_out;
	logic upper_data_port_oe_out;
	int err_count = 0;
	int total_checks = 0;
	int pin_of [8] = '{0, 1, 5, 2, 3, 4, 5, 6};
	int cs5_pin [4] = '{4, 3, 9, 7};
	always #25 clk_in = ~clk_in;
	chip_select_pin_enable i_dut (.clk_in, .rst_b_in, .reg_addr_in,
		.reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out,
		.area_select_output_b_in, .access_area_in, .data_hi_in,
		.data_hi_drive_in, .select_pin_level_out, .select_pin_mode_out,
		.upper_data_port_bus_mode_out, .upper_data_port_out,
		.upper_data_port_oe_out);
	task ck(input logic [9:0] g, input logic [9:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	// step 1 ns past the edge so the outputs have settled
	task cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_write_in <= 1'h1;
		@(posedge clk_in);
		reg_write_in <= 1'h0;
		#1;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_read_in <= 1'h1;
		@(posedge clk_in);
		reg_read_in <= 1'h0;
		#1;
		ck(reg_rdata_out, e);
	endtask
	task wd(input logic [2:0] a, input logic wide);
		@(posedge clk_in);
		access_area_in <= a;
		cyc(1);
		ck({upper_data_port_bus_mode_out, upper_data_port_oe_out}, {2{wide}});
		ck(upper_data_port_out, wide ? 8'hA5 : 8'h00);
	endtask
	task t_reset;
		rd(4'h0, 8'h01);
		ck(select_pin_mode_out, 10'h001);
		rd(4'h8, 8'hFF);
		rd(4'h9, 8'h03);
		$display("end t_reset");
	endtask
	task t_enables;
		for (int n = 0; n < 8; n++) begin
			wr(4'h0, 8'h01 << n);
			ck(select_pin_mode_out, 10'h001 << pin_of[n]);
			rd(4'h0, 8'h01 << n);
			@(posedge clk_in);
			area_select_output_b_in <= ~(8'h01 << n);
			cyc(1);
			ck(select_pin_level_out, ~(10'h001 << pin_of[n]));
			@(posedge clk_in);
			area_select_output_b_in <= 8'hFF;
		end
		wr(4'h0, 8'h00);
		ck(select_pin_mode_out, 10'h000);
		$display("end t_enables");
	endtask
	// in the sweep select 4 sits on a prohibited code, so it must stay off
	task t_route;
		wr(4'h0, 8'h30);
		for (int c = 0; c < 4; c++) begin
			wr(4'h1, 8'(4 * c + 1));
			ck(select_pin_mode_out, 10'h001 << cs5_pin[c]);
			rd(4'h7, 8'h10);
		end
		// selects 6 and 7 share one pin; only select 7 is driven active, and it pulls the pin low
		wr(4'h0, 8'hC0);
		wr(4'h1, 8'hA0);
		ck(select_pin_mode_out, 10'h200);
		@(posedge clk_in);
		area_select_output_b_in <= 8'h7F;
		cyc(1);
		ck(select_pin_level_out, 10'h1FF);
		@(posedge clk_in);
		area_select_output_b_in <= 8'hFF;
		wr(4'h1, 8'hF0);
		ck(select_pin_mode_out, 10'h100);
		rd(4'h7, 8'h80);
		rd(4'h5, 8'h00);
		rd(4'h6, 8'h01);
		wr(4'h0, 8'h10);
		wr(4'h1, 8'h02);
		ck(select_pin_mode_out, 10'h200);
		wr(4'h0, 8'h04);
		wr(4'h2, 8'h01);
		ck(select_pin_mode_out, 10'h010);
		rd(4'h2, 8'h01);
		$display("end t_route");
	endtask
	task t_width;
		wd(3'h2, 1'h1);
		wr(4'h3, 8'h04);
		wd(3'h2, 1'h0);
		wr(4'h4, 8'hDF);
		wd(3'h5, 1'h0);
		wd(3'h1, 1'h1);
		// the output enable follows the drive request, not the area alone
		@(posedge clk_in);
		data_hi_drive_in <= 1'h0;
		data_hi_in <= 8'h3C;
		cyc(1);
		ck(upper_data_port_bus_mode_out, 1'h1);
		ck(upper_data_port_oe_out, 1'h0);
		ck(upper_data_port_out, 8'h3C);
		@(posedge clk_in);
		data_hi_drive_in <= 1'h1;
		data_hi_in <= 8'hA5;
		$display("end t_width");
	endtask
	task t_again;
		rd(4'hC, 8'h00);
		wr(4'h0, 8'hFF);
		@(posedge clk_in);
		rst_b_in <= 1'h0;
		#1;
		ck(select_pin_mode_out, 10'h000);
		ck(select_pin_level_out, 10'h3FF);
		@(posedge clk_in);
		rst_b_in <= 1'h1;
		cyc(2);
		rd(4'h0, 8'h01);
		ck(select_pin_mode_out, 10'h001);
		rd(4'h1, 8'h00);
		rd(4'h2, 8'h00);
		rd(4'h3, 8'h00);
		$display("end t_again");
	endtask
	task conclude;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_in);
		rst_b_in <= 1'h1;
		cyc(2);
		t_reset();
		t_enables();
		t_route();
		t_width();
		t_again();
		conclude();
	end
endmodule
